// ===== inc/dfr_pkg.sv
// package: register indices, reset values and reaction code decoding
package dfr_pkg;
   localparam int          ADDR_W                   = 18;
   localparam int          IDX_W                    = 16;
   localparam logic [15:0] DEV_REACT_IDX            = 16'h3700;
   localparam logic [15:0] LIMIT_REACT_IDX          = 16'h3701;
   localparam logic [15:0] HW_INFO_IDX              = 16'h4012;
   localparam logic [15:0] HW_CFG_IDX               = 16'h4013;
   localparam logic [15:0] OP_COND_IDX              = 16'h4014;
   localparam logic [15:0] SUB_COUNT_IDX            = 16'h5000;
   localparam logic [15:0] OP_COND_SEL_IDX          = 16'h5001;
   localparam logic [15:0] DRIVE_STATE_REPORT_INDEX = 16'h6041;
   localparam logic [15:0] REACT_RESET              = 16'hffff;
   localparam logic [31:0] HW_CFG_RESET             = 32'h0000_0000;
   localparam logic [7:0]  HIGHEST_SUB              = 8'h01;
   localparam int          WARN_BIT                 = 7;
   localparam int          OPC_N                    = 5;
   localparam logic [2:0]  OPC_SEL_RESET            = 3'h0;
   localparam logic [2:0]  OPC_SEL_LAST             = 3'h4;
   localparam logic [15:0] DEV_BLOCK                = 16'h0000;
   localparam logic [15:0] DEV_SLOW                 = 16'h0001;
   localparam logic [15:0] DEV_QUICK                = 16'h0002;
   localparam logic [15:0] LIM_NONE                 = 16'hffff;
   localparam logic [15:0] LIM_SLOW_SOD             = 16'h0001;
   localparam logic [15:0] LIM_QUICK_SOD            = 16'h0002;
   localparam logic [15:0] LIM_SLOW_QSA             = 16'h0005;
   localparam logic [15:0] LIM_QUICK_QSA            = 16'h0006;

   typedef enum logic [1:0] {DFR_FIN_NONE, DFR_FIN_SOD, DFR_FIN_QSA} dfr_fin_e;

   typedef struct packed {
      logic     valid;
      logic     block;
      logic     brake;
      logic     quick;
      dfr_fin_e fin;
   } dfr_plan_s;

   function automatic dfr_plan_s dfr_dev_plan(input logic [15:0] code);
      dfr_plan_s p;
      p = '0;
      p.valid = 1'b1;
      case (code)
         DEV_BLOCK: p.block = 1'b1;
         DEV_SLOW:  p.brake = 1'b1;
         DEV_QUICK: begin
            p.brake = 1'b1;
            p.quick = 1'b1;
         end
         default:   p.valid = 1'b0;
      endcase
      return p;
   endfunction : dfr_dev_plan

   function automatic dfr_plan_s dfr_lim_plan(input logic [15:0] code);
      dfr_plan_s p;
      p = '0;
      p.valid = 1'b1;
      p.brake = 1'b1;
      case (code)
         LIM_NONE:      p.brake = 1'b0;
         LIM_SLOW_SOD:  p.fin = DFR_FIN_SOD;
         LIM_QUICK_SOD: begin
            p.quick = 1'b1;
            p.fin   = DFR_FIN_SOD;
         end
         LIM_SLOW_QSA:  p.fin = DFR_FIN_QSA;
         LIM_QUICK_QSA: begin
            p.quick = 1'b1;
            p.fin   = DFR_FIN_QSA;
         end
         default: begin
            p.valid = 1'b0;
            p.brake = 1'b0;
         end
      endcase
      return p;
   endfunction : dfr_lim_plan
endpackage : dfr_pkg

// ===== hdl/dfr_apb_port.sv
// apb slave handshake: one wait state, registered answer
`timescale 1ns/1ps
module dfr_apb_port (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] rd_data,
   input  wire logic        acc_err,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic             wr_en
);
   import dfr_pkg::*;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } dfr_apb_s;

   dfr_apb_s r;
   dfr_apb_s next_r;

   // answer is sampled during the first access cycle, so data and error match the held request
   always_comb begin
      next_r = r;
      next_r.pready = psel & penable & ~r.pready;
      if (psel && penable && !r.pready) begin
         next_r.prdata  = pwrite ? 32'h0000_0000 : rd_data;
         next_r.pslverr = acc_err;
      end else begin
         // error stands with pready only, so a held psel cannot stretch it
         next_r.pslverr = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // refused writes carry pslverr and never reach the registers
   assign wr_en   = psel & penable & r.pready & pwrite & ~r.pslverr;
   assign pready  = r.pready;
   assign prdata  = r.prdata;
   assign pslverr = r.pslverr;
endmodule : dfr_apb_port

// ===== hdl/dfr_reaction_seq.sv
// runs one fault reaction: block, or brake then request any state change the plan names
`timescale 1ns/1ps
module dfr_reaction_seq (
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic              start,
   input  wire dfr_pkg::dfr_plan_s plan,
   input  wire logic [7:0]        op_mode,
   input  wire logic              ramp_done,
   output logic                   busy,
   output logic                   brake_req,
   output logic                   brake_quick,
   output logic [7:0]             slow_ramp_mode,
   output logic                   drive_block,
   output logic                   go_switch_on_disabled,
   output logic                   go_quick_stop_active
);
   import dfr_pkg::*;

   typedef enum logic {DFR_IDLE, DFR_BRAKE} dfr_seq_e;

   typedef struct packed {
      dfr_seq_e   st;
      logic       brake;
      logic       quick;
      dfr_fin_e   fin;
      logic [7:0] mode;
      logic       block;
      logic       go_sod;
      logic       go_qsa;
   } dfr_seq_s;

   dfr_seq_s r;
   dfr_seq_s next_r;

   always_comb begin
      next_r = r;
      next_r.block  = 1'b0;
      next_r.go_sod = 1'b0;
      next_r.go_qsa = 1'b0;
      next_r.mode   = op_mode;
      case (r.st)
         DFR_IDLE: begin
            if (start && plan.valid) begin
               next_r.block = plan.block;
               if (plan.brake) begin
                  next_r.st    = DFR_BRAKE;
                  next_r.brake = 1'b1;
                  next_r.quick = plan.quick;
                  next_r.fin   = plan.fin;
               end
            end
         end
         DFR_BRAKE: begin
            if (ramp_done) begin
               next_r.st     = DFR_IDLE;
               next_r.brake  = 1'b0;
               next_r.go_sod = (r.fin == DFR_FIN_SOD);
               // quick-stop bit of the control word is left to software
               next_r.go_qsa = (r.fin == DFR_FIN_QSA);
            end
         end
         default: next_r.st = DFR_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign busy                  = (r.st != DFR_IDLE);
   assign brake_req             = r.brake;
   assign brake_quick           = r.quick;
   assign slow_ramp_mode        = r.mode;
   assign drive_block           = r.block;
   assign go_switch_on_disabled = r.go_sod;
   assign go_quick_stop_active  = r.go_qsa;
endmodule : dfr_reaction_seq

// ===== hdl/dfr_fault_objects.sv
// top: fault reaction and hardware information registers behind apb
`timescale 1ns/1ps
module dfr_fault_objects (
   input  wire logic                       ref_clk,
   input  wire logic                       srst,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [dfr_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic                            pready,
   output logic [31:0]                     prdata,
   output logic                            pslverr,
   input  wire logic                       deviation_err,
   input  wire logic                       limit_passed,
   input  wire logic                       ramp_done,
   input  wire logic [7:0]                 op_mode,
   input  wire logic [31:0]                eeprom_size,
   input  wire logic [31:0]                op_cond_supply_mv,
   input  wire logic [31:0]                op_cond_logic_mv,
   input  wire logic [31:0]                op_cond_board_temp,
   input  wire logic [31:0]                op_cond_spare_a,
   input  wire logic [31:0]                op_cond_spare_b,
   output logic                            status_warning,
   output logic [31:0]                     hw_config,
   output logic                            reaction_busy,
   output logic                            brake_req,
   output logic                            brake_quick,
   output logic [7:0]                      slow_ramp_mode,
   output logic                            drive_block,
   output logic                            go_switch_on_disabled,
   output logic                            go_quick_stop_active
);
   import dfr_pkg::*;

   typedef struct packed {
      logic [15:0] dev_react;
      logic [15:0] lim_react;
      logic [31:0] hw_cfg;
      logic [2:0]  opc_sel;
      logic        warn;
      logic        ev_start;
      dfr_plan_s   ev_plan;
      logic        busy;
   } dfr_top_s;

   dfr_top_s          r;
   dfr_top_s          next_r;
   logic [IDX_W-1:0]  idx;
   logic              misaligned;
   logic [31:0]       rd_data;
   logic              acc_err;
   logic              wr_en;
   logic              seq_busy;
   dfr_plan_s         dev_wr_plan;
   dfr_plan_s         lim_wr_plan;
   logic [31:0]       opc [OPC_N];

   // live measurements, sampled straight into the read path
   assign opc[0] = op_cond_supply_mv;
   assign opc[1] = op_cond_logic_mv;
   assign opc[2] = op_cond_board_temp;
   assign opc[3] = op_cond_spare_a;
   assign opc[4] = op_cond_spare_b;

   // word addressing: byte address is four times the index
   assign idx         = paddr[ADDR_W-1:2];
   assign misaligned  = |paddr[1:0];
   assign dev_wr_plan = dfr_dev_plan(pwdata[15:0]);
   assign lim_wr_plan = dfr_lim_plan(pwdata[15:0]);

   // read mux and refusal decode for the request currently held on the bus
   always_comb begin
      rd_data = 32'h0000_0000;
      acc_err = 1'b0;
      case (idx)
         DEV_REACT_IDX: begin
            rd_data = {16'h0000, r.dev_react};
            acc_err = pwrite & ~dev_wr_plan.valid;
         end
         LIMIT_REACT_IDX: begin
            rd_data = {16'h0000, r.lim_react};
            acc_err = pwrite & ~lim_wr_plan.valid;
         end
         HW_INFO_IDX: begin
            rd_data = eeprom_size;
         end
         HW_CFG_IDX: begin
            rd_data = r.hw_cfg;
         end
         OP_COND_IDX: begin
            rd_data = opc[r.opc_sel];
         end
         SUB_COUNT_IDX: begin
            rd_data = {16'h0000, HIGHEST_SUB, HIGHEST_SUB};
         end
         OP_COND_SEL_IDX: begin
            rd_data = {29'h0000_0000, r.opc_sel};
            acc_err = pwrite & (pwdata[31:0] > {29'h0000_0000, OPC_SEL_LAST});
         end
         DRIVE_STATE_REPORT_INDEX: begin
            rd_data[WARN_BIT] = r.warn;
         end
         default: begin
            acc_err = 1'b1;
         end
      endcase
      if (misaligned) begin
         acc_err = 1'b1;
      end
   end

   always_comb begin
      next_r = r;
      next_r.ev_start = 1'b0;
      next_r.busy     = seq_busy;
      if (wr_en) begin
         case (idx)
            DEV_REACT_IDX: begin
               next_r.dev_react = pwdata[15:0];
            end
            LIMIT_REACT_IDX: begin
               next_r.lim_react = pwdata[15:0];
            end
            HW_CFG_IDX: begin
               next_r.hw_cfg = pwdata;
            end
            OP_COND_SEL_IDX: begin
               next_r.opc_sel = pwdata[2:0];
            end
            DRIVE_STATE_REPORT_INDEX: begin
               if (pwdata[WARN_BIT]) begin
                  next_r.warn = 1'b0;
               end
            end
            default: begin
               next_r.warn = r.warn;
            end
         endcase
      end
      // set after clear, so a switch passed during the clear is not lost
      if (limit_passed) begin
         next_r.warn     = 1'b1;
         next_r.ev_start = 1'b1;
         next_r.ev_plan  = dfr_lim_plan(r.lim_react);
      end
      // a following error outranks a switch event in the same cycle
      if (deviation_err) begin
         next_r.ev_start = 1'b1;
         next_r.ev_plan  = dfr_dev_plan(r.dev_react);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         r           <= '0;
         r.dev_react <= REACT_RESET;
         r.lim_react <= REACT_RESET;
         r.hw_cfg    <= HW_CFG_RESET;
         r.opc_sel   <= OPC_SEL_RESET;
      end else begin
         r <= next_r;
      end
   end

   dfr_apb_port u_apb (
      .ref_clk (ref_clk),
      .srst    (srst),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .rd_data (rd_data),
      .acc_err (acc_err),
      .pready  (pready),
      .prdata  (prdata),
      .pslverr (pslverr),
      .wr_en   (wr_en)
   );

   // events that arrive while a reaction runs are not queued
   dfr_reaction_seq u_seq (
      .ref_clk               (ref_clk),
      .srst                  (srst),
      .start                 (r.ev_start),
      .plan                  (r.ev_plan),
      .op_mode               (op_mode),
      .ramp_done             (ramp_done),
      .busy                  (seq_busy),
      .brake_req             (brake_req),
      .brake_quick           (brake_quick),
      .slow_ramp_mode        (slow_ramp_mode),
      .drive_block           (drive_block),
      .go_switch_on_disabled (go_switch_on_disabled),
      .go_quick_stop_active  (go_quick_stop_active)
   );

   assign status_warning = r.warn;
   assign hw_config      = r.hw_cfg;
   assign reaction_busy  = r.busy;
endmodule : dfr_fault_objects

// ===== bench/dfr_fault_objects_monitor.sv
// checker: apb timing and fault reaction relations at the top ports
`timescale 1ns/1ps
module dfr_fault_objects_monitor (
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        deviation_err,
   input wire logic        limit_passed,
   input wire logic        ramp_done,
   input wire logic [7:0]  op_mode,
   input wire logic        status_warning,
   input wire logic        brake_req,
   input wire logic        brake_quick,
   input wire logic [7:0]  slow_ramp_mode,
   input wire logic        drive_block,
   input wire logic        go_switch_on_disabled,
   input wire logic        go_quick_stop_active
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence access_start;
      psel && $rose(penable);
   endsequence
   sequence brake_end;
      brake_req && ramp_done;
   endsequence
   sequence dev_ago;
      $past(deviation_err, 2);
   endsequence
   sequence event_ago;
      $past(deviation_err, 2) || $past(limit_passed, 2);
   endsequence
   sequence slow_braking;
      brake_req && !brake_quick;
   endsequence
   sequence state_rise;
      $rose(go_quick_stop_active) || $rose(go_switch_on_disabled);
   endsequence
   sequence brake_fell;
      $past(brake_req) && !brake_req;
   endsequence
   sequence no_state_req;
      !(go_quick_stop_active || go_switch_on_disabled);
   endsequence
   apb_wait_a: assert property (access_start |=> pready ##1 !pready)
      else $error("pready not one cycle after access start");
   err_ready_a: assert property (pslverr |-> pready && $past(penable))
      else $error("pslverr outside an answer");
   write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("prdata not zero on write");
   warn_set_a: assert property (limit_passed |=> status_warning)
      else $error("warning not set after limit event");
   block_timing_a: assert property (drive_block |-> dev_ago ##1 !drive_block)
      else $error("drive block pulse misplaced");
   brake_timing_a: assert property ($rose(brake_req) |-> event_ago)
      else $error("brake start not two cycles after event");
   slow_ramp_a: assert property (slow_braking |-> slow_ramp_mode == $past(op_mode))
      else $error("slow ramp mode not the active mode");
   brake_release_a: assert property (brake_end |=> !brake_req)
      else $error("brake held after ramp done");
   state_req_a: assert property (state_rise |-> brake_fell ##1 no_state_req)
      else $error("state change request misplaced");
   state_excl_a: assert property (!(go_quick_stop_active && go_switch_on_disabled))
      else $error("two state change requests at once");
endmodule : dfr_fault_objects_monitor

bind dfr_fault_objects dfr_fault_objects_monitor mon_u (.ref_clk, .srst, .psel, .penable,
   .pwrite, .pready, .prdata, .pslverr, .deviation_err, .limit_passed, .ramp_done, .op_mode,
   .status_warning, .brake_req, .brake_quick, .slow_ramp_mode, .drive_block,
   .go_switch_on_disabled, .go_quick_stop_active);

// ===== bench/dfr_fault_objects_tb.sv
// testbench: register map and fault reactions of the fault objects block
`timescale 1ns/1ps
module dfr_fault_objects_tb;
   import dfr_pkg::*;
   logic              ref_clk = 1'b0;
   logic              srst = 1'b1;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = 32'h0;
   logic              deviation_err = 1'b0;
   logic              limit_passed = 1'b0;
   logic              ramp_done = 1'b0;
   logic [7:0]        op_mode = 8'h03;
   logic [31:0]       eeprom_size = 32'h0000_0800;
   logic [31:0]       opc [5] = '{32'h0000_5dc0, 32'h0000_12c0, 32'hffff_ff9c,
                                  32'h7fff_ffff, 32'h8000_0000};
   logic              pready, pslverr, status_warning, reaction_busy, brake_req, brake_quick;
   logic              drive_block, go_switch_on_disabled, go_quick_stop_active;
   logic [31:0]       prdata, hw_config, rdat;
   logic [7:0]        slow_ramp_mode;
   int                n_mismatch = 0;
   int                n_tests = 0;

   always #4 ref_clk = ~ref_clk;

   dfr_fault_objects dut_u (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .deviation_err, .limit_passed, .ramp_done, .op_mode, .eeprom_size,
      .op_cond_supply_mv(opc[0]), .op_cond_logic_mv(opc[1]), .op_cond_board_temp(opc[2]),
      .op_cond_spare_a(opc[3]), .op_cond_spare_b(opc[4]), .status_warning, .hw_config,
      .reaction_busy, .brake_req, .brake_quick, .slow_ramp_mode, .drive_block,
      .go_switch_on_disabled, .go_quick_stop_active);

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // a full apb transfer; a dead slave is left to the watchdog
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      input logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      chk(32'(pslverr), 32'(err));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_is(input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0, 1'b0);
      chk(rdat, exp);
   endtask : rd_is

   task automatic t_reset;
      rd_is(DEV_REACT_IDX, 32'h0000_ffff);
      rd_is(LIMIT_REACT_IDX, 32'h0000_ffff);
      rd_is(HW_CFG_IDX, 32'h0);
      chk(hw_config, 32'h0);
      rd_is(SUB_COUNT_IDX, 32'h0000_0101);
      rd_is(16'h6041, 32'h0);
   endtask : t_reset

   task automatic t_regs;
      apb(1'b1, HW_CFG_IDX, 32'ha5c3_5a3c, 1'b0);
      rd_is(HW_CFG_IDX, 32'ha5c3_5a3c);
      chk(hw_config, 32'ha5c3_5a3c);
      rd_is(HW_INFO_IDX, 32'h0000_0800);
      apb(1'b1, HW_INFO_IDX, 32'h1234_5678, 1'b0);
      eeprom_size <= 32'h0;
      rd_is(HW_INFO_IDX, 32'h0);
      apb(1'b1, SUB_COUNT_IDX, 32'h0, 1'b0);
      rd_is(SUB_COUNT_IDX, 32'h0000_0101);
      apb(1'b1, 16'h7000, 32'h0, 1'b1);
      for (int i = 0; i < OPC_N; i++) begin
         apb(1'b1, OP_COND_SEL_IDX, 32'(i), 1'b0);
         rd_is(OP_COND_IDX, opc[i]);
      end
      apb(1'b1, OP_COND_SEL_IDX, 32'h5, 1'b1);
      apb(1'b1, OP_COND_IDX, 32'h0, 1'b0);
      rd_is(OP_COND_IDX, opc[4]);
   endtask : t_regs

   task automatic t_refuse;
      apb(1'b1, DEV_REACT_IDX, 32'h2, 1'b0);
      apb(1'b1, DEV_REACT_IDX, 32'h3, 1'b1);
      apb(1'b1, DEV_REACT_IDX, 32'hffff, 1'b1);
      rd_is(DEV_REACT_IDX, 32'h2);
      apb(1'b1, LIMIT_REACT_IDX, 32'h5, 1'b0);
      apb(1'b1, LIMIT_REACT_IDX, 32'h3, 1'b1);
      apb(1'b1, LIMIT_REACT_IDX, 32'h0, 1'b1);
      rd_is(LIMIT_REACT_IDX, 32'h5);
   endtask : t_refuse

   // one event under a stored code; e = {block, brake, quick, to_sod, to_qsa}
   task automatic evt(input logic lim, input logic [15:0] code, input logic [4:0] e);
      if (lim || code !== REACT_RESET) begin
         apb(1'b1, lim ? LIMIT_REACT_IDX : DEV_REACT_IDX, 32'(code), 1'b0);
      end
      @(posedge ref_clk);
      deviation_err <= !lim;
      limit_passed <= lim;
      @(posedge ref_clk);
      deviation_err <= 1'b0;
      limit_passed <= 1'b0;
      #1;
      if (lim) chk(32'(status_warning), 32'h1);
      @(posedge ref_clk);
      #1;
      chk(32'({drive_block, brake_req}), 32'(e[4:3]));
      // the ramp choice only means something while braking
      if (e[3]) chk(32'(brake_quick), 32'(e[2]));
      if (e[3] && !e[2]) chk(32'(slow_ramp_mode), 32'(op_mode));
      repeat (3) @(posedge ref_clk);
      #1;
      chk(32'({drive_block, brake_req, reaction_busy}), 32'({1'b0, e[3], e[3]}));
      @(posedge ref_clk);
      ramp_done <= 1'b1;
      op_mode <= op_mode + 8'h01;
      @(posedge ref_clk);
      ramp_done <= 1'b0;
      #1;
      chk(32'({brake_req, go_switch_on_disabled, go_quick_stop_active}), 32'(e[1:0]));
      if (e[3] && !e[2]) chk(32'(slow_ramp_mode), 32'(op_mode));
      @(posedge ref_clk);
      #1;
      chk(32'({go_switch_on_disabled, go_quick_stop_active, reaction_busy}), 32'h0);
      if (lim) apb(1'b1, 16'h6041, 32'h80, 1'b0);
      if (lim) rd_is(16'h6041, 32'h0);
   endtask : evt

   task automatic t_dev;
      // the reserved deviation preset needs a fresh reset
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      chk(hw_config, 32'h0);
      rd_is(DEV_REACT_IDX, 32'h0000_ffff);
      evt(1'b0, REACT_RESET, 5'b00000);
      evt(1'b0, DEV_BLOCK, 5'b10000);
      op_mode <= 8'h06;
      evt(1'b0, DEV_SLOW, 5'b01000);
      evt(1'b0, DEV_QUICK, 5'b01100);
   endtask : t_dev

   task automatic t_lim;
      evt(1'b1, LIM_NONE, 5'b00000);
      evt(1'b1, LIM_SLOW_SOD, 5'b01010);
      evt(1'b1, LIM_QUICK_SOD, 5'b01110);
      evt(1'b1, LIM_SLOW_QSA, 5'b01001);
      evt(1'b1, LIM_QUICK_QSA, 5'b01101);
   endtask : t_lim

   initial begin
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      t_reset();
      t_regs();
      t_refuse();
      t_dev();
      t_lim();
      final_report();
   end

   // the whole sequence needs well under a thousand cycles
   initial begin
      #(8 * 5000);
      n_mismatch++;
      final_report();
   end
endmodule : dfr_fault_objects_tb
